// >>> logic/usbs_map.svh
`ifndef USBS_MAP_SVH
`define USBS_MAP_SVH
// register indices; byte address is four times the index
`define USBS_IDX_MPS 8'h04
`define USBS_IDX_BCNT 8'h1C
`define USBS_IDX_FILL 8'h1E
`define USBS_IDX_EPSEL 8'h2C
`define USBS_IDX_EPCFG 8'h2D
// field positions
`define USBS_FSZ_LSB 0
`define USBS_FSZ_MSB 10
`define USBS_NTR_LSB 11
`define USBS_NTR_MSB 12
// reset values
`define USBS_RST_BCNT 16'h0000
`define USBS_RST_MPS 13'h0000
`define USBS_RST_FILL 2'h0
`define USBS_RST_TYP 2'h0
// endpoint type codes and the reserved microframe count code
`define USBS_TYP_ISO 2'h1
`define USBS_TYP_INT 2'h3
`define USBS_NTR_RSVD 2'h3
`endif

// >>> logic/usbs_pkg.sv
`default_nettype none
package usbs_pkg;
	typedef struct packed {
		logic [9:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} usbs_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} usbs_avs_rsp_t;

	typedef struct packed {
		logic wait_n;
		logic [31:0] rdata;
		logic [3:0] idx;
		logic [15:0][1:0] typ;
		logic [15:0][12:0] mps;
		logic [15:0][15:0] bcnt;
		logic [15:0][1:0] fill;
		logic [15:0] wcnt;
		logic [15:0] rcnt;
		logic val;
		logic clr;
		logic [1:0] lanes;
		logic [1:0] ppu;
	} usbs_state_t;
endpackage
`default_nettype wire

// >>> logic/usbs_ep_sizing.sv
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "usbs_map.svh"
module usbs_ep_sizing (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire usbs_pkg::usbs_avs_req_t i_avs,
	output usbs_pkg::usbs_avs_rsp_t o_avs,
	input wire logic i_bus_reset,
	input wire logic i_high_speed,
	input wire logic i_pio_wr,
	input wire logic i_pio_rd,
	input wire logic i_pio_wide,
	input wire logic i_in_sent,
	input wire logic [2:0] i_in_sent_ep,
	input wire logic i_out_ack,
	input wire logic [2:0] i_out_ep,
	input wire logic [10:0] i_out_bytes,
	output logic o_in_validate,
	output logic o_out_clear,
	output logic [1:0] o_rd_lanes,
	output logic [1:0] o_pkts_per_microframe
);
	import usbs_pkg::*;

	usbs_state_t s_q;
	usbs_state_t s_d;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] f_merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
		f_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic [15:0] f_step(input logic wide);
		f_step = wide ? 16'h0002 : 16'h0001;
	endfunction

	function automatic logic f_reg(input logic [9:0] addr, input logic [7:0] idx);
		f_reg = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	logic req;
	logic [3:0] sel;
	logic [15:0] wr16;
	logic [15:0] fsz;
	logic [15:0] limit;
	assign req = i_avs.read | i_avs.write;
	assign sel = s_q.idx;
	assign wr16 = i_avs.writedata[15:0];
	assign fsz = {5'h00, s_q.mps[sel][`USBS_FSZ_MSB:`USBS_FSZ_LSB]};
	assign limit = (s_q.bcnt[sel] != 16'h0000 && s_q.bcnt[sel] < fsz) ? s_q.bcnt[sel] : fsz;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [15:0] inc;
		logic [15:0] dec;
		logic [15:0] nw;
		logic [15:0] left;
		inc = 16'h0000;
		dec = 16'h0000;
		nw = 16'h0000;
		left = 16'h0000;
		s_d = s_q;
		s_d.val = 1'b0;
		s_d.clr = 1'b0;
		s_d.wait_n = 1'b0;
		if (req && !s_q.wait_n) begin
			s_d.wait_n = 1'b1;
			s_d.rdata = 32'h0000_0000;
			if (i_avs.read) begin
				if (f_reg(i_avs.address, `USBS_IDX_MPS) && sel[3:1] != 3'h0) begin
					s_d.rdata = {19'h00000, s_q.mps[sel]};
				end else if (f_reg(i_avs.address, `USBS_IDX_BCNT)) begin
					s_d.rdata = {16'h0000, s_q.bcnt[sel]};
				end else if (f_reg(i_avs.address, `USBS_IDX_FILL)) begin
					// count of full buffers shown as 00, 01 or 11
					s_d.rdata = {30'h0, s_q.fill[sel] == 2'h2 ? 2'h3 : s_q.fill[sel]};
				end else if (f_reg(i_avs.address, `USBS_IDX_EPSEL)) begin
					s_d.rdata = {28'h0, sel};
				end else if (f_reg(i_avs.address, `USBS_IDX_EPCFG)) begin
					s_d.rdata = {30'h0, s_q.typ[sel]};
				end
			end else begin
				if (f_reg(i_avs.address, `USBS_IDX_MPS) && sel[3:1] != 3'h0) begin
					// control endpoint slots ignore sizing writes
					nw = f_merge({3'h0, s_q.mps[sel]}, wr16, i_avs.byteenable[1:0]);
					s_d.mps[sel] = nw[12:0];
					s_d.bcnt[sel] = {5'h00, nw[`USBS_FSZ_MSB:`USBS_FSZ_LSB]};
				end else if (f_reg(i_avs.address, `USBS_IDX_BCNT)) begin
					s_d.bcnt[sel] = f_merge(s_q.bcnt[sel], wr16, i_avs.byteenable[1:0]);
				end else if (f_reg(i_avs.address, `USBS_IDX_EPSEL) && i_avs.byteenable[0]) begin
					s_d.idx = wr16[3:0];
					s_d.wcnt = 16'h0000;
					s_d.rcnt = 16'h0000;
				end else if (f_reg(i_avs.address, `USBS_IDX_EPCFG) && i_avs.byteenable[0]) begin
					s_d.typ[sel] = wr16[1:0];
				end
			end
		end
		// only processor data writes advance the count
		if (i_pio_wr && sel[0]) begin
			// full packets validate at fifo size
			// short packets validate at programmed count
			if (s_q.wcnt + f_step(i_pio_wide) >= limit) begin
				s_d.val = 1'b1;
				s_d.wcnt = 16'h0000;
				inc[sel] = 1'b1;
			end else begin
				s_d.wcnt = s_q.wcnt + f_step(i_pio_wide);
			end
		end
		if (i_pio_rd && !sel[0]) begin
			left = s_q.bcnt[sel] - s_q.rcnt;
			// odd last byte on lower lane
			s_d.lanes = (i_pio_wide && left != 16'h0001) ? 2'h3 : 2'h1;
			// all bytes read clears the buffer
			if (s_q.rcnt + f_step(i_pio_wide) >= s_q.bcnt[sel]) begin
				s_d.clr = 1'b1;
				s_d.rcnt = 16'h0000;
				dec[sel] = 1'b1;
			end else begin
				s_d.rcnt = s_q.rcnt + f_step(i_pio_wide);
			end
		end
		// buffer leaves on the next in token
		if (i_in_sent) begin
			dec[{i_in_sent_ep, 1'b1}] = 1'b1;
		end
		if (i_out_ack) begin
			s_d.bcnt[{i_out_ep, 1'b0}] = {5'h00, i_out_bytes};
			inc[{i_out_ep, 1'b0}] = 1'b1;
		end
		// a fill and a drain in one cycle cancel, so neither event is lost
		for (int k = 0; k < 16; k++) begin
			if (inc[k] && !dec[k] && s_q.fill[k] != 2'h2) begin
				s_d.fill[k] = s_q.fill[k] + 2'h1;
			end else if (dec[k] && !inc[k] && s_q.fill[k] != 2'h0) begin
				s_d.fill[k] = s_q.fill[k] - 2'h1;
			end
		end
		// microframe count only for hs iso or interrupt
		if (i_high_speed && (s_q.typ[sel] == `USBS_TYP_ISO || s_q.typ[sel] == `USBS_TYP_INT)
				&& s_q.mps[sel][`USBS_NTR_MSB:`USBS_NTR_LSB] != `USBS_NTR_RSVD) begin
			s_d.ppu = s_q.mps[sel][`USBS_NTR_MSB:`USBS_NTR_LSB];
		end else begin
			s_d.ppu = 2'h0;
		end
		if (i_bus_reset) begin
			for (int k = 0; k < 16; k++) begin
				s_d.bcnt[k] = `USBS_RST_BCNT;
				s_d.fill[k] = `USBS_RST_FILL;
			end
			s_d.wcnt = 16'h0000;
			s_d.rcnt = 16'h0000;
			s_d.val = 1'b0;
			s_d.clr = 1'b0;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_avs.readdata = s_q.rdata;
	assign o_avs.waitrequest = ~s_q.wait_n;
	assign o_in_validate = s_q.val;
	assign o_out_clear = s_q.clr;
	assign o_rd_lanes = s_q.lanes;
	assign o_pkts_per_microframe = s_q.ppu;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	sequence seq_taken;
		req && !s_q.wait_n;
	endsequence
	sequence seq_done;
		s_q.wait_n ##1 !s_q.wait_n;
	endsequence
	sequence seq_wr_bcnt;
		seq_taken ##0 (i_avs.write && f_reg(i_avs.address, `USBS_IDX_BCNT) && i_avs.byteenable[1:0] == 2'h3);
	endsequence
	sequence seq_rd_bcnt;
		seq_taken ##0 (i_avs.read && f_reg(i_avs.address, `USBS_IDX_BCNT));
	endsequence
	sequence seq_wr_ctrl_mps;
		seq_taken ##0 (i_avs.write && f_reg(i_avs.address, `USBS_IDX_MPS) && sel[3:1] == 3'h0);
	endsequence

	a_bus_handshake: assert property (seq_taken |=> seq_done)
		else $error("waitrequest not one-cycle answer");

	a_mps_reload: assert property (seq_taken and (i_avs.write && f_reg(i_avs.address, `USBS_IDX_MPS)
			&& sel[3:1] != 3'h0 && i_avs.byteenable[1:0] == 2'h3 && !i_out_ack && !i_bus_reset)
			|=> s_q.bcnt[$past(sel)] == {5'h00, $past(wr16[10:0])})
		else $error("byte count not reloaded");

	a_bus_reset_clr: assert property (i_bus_reset |=> s_q.bcnt == '0 ##1 1'b1)
		else $error("byte count not cleared");

	a_out_load: assert property (i_out_ack && !i_bus_reset
			|=> s_q.bcnt[{$past(i_out_ep), 1'b0}] == {5'h00, $past(i_out_bytes)})
		else $error("out length not loaded");

	a_fill_code: assert property (s_q.fill[sel] != 2'h3)
		else $error("fill count out of range");

	a_rsvd_zero: assert property (seq_taken and (i_avs.read && f_reg(i_avs.address, `USBS_IDX_FILL))
			|=> s_q.rdata[31:2] == 30'h0)
		else $error("reserved bits not zero");

	a_ppu_ignore: assert property (!i_high_speed |=> s_q.ppu == 2'h0)
		else $error("microframe count used outside hs");

	a_val_limit: assert property (i_pio_wr && sel[0] && !i_bus_reset
			&& s_q.wcnt + f_step(i_pio_wide) >= limit |=> o_in_validate && s_q.wcnt == 16'h0)
		else $error("short packet not validated");

	a_lane_odd: assert property (i_pio_rd && !sel[0] && i_pio_wide && !i_bus_reset
			&& s_q.bcnt[sel] - s_q.rcnt == 16'h0001 |=> o_rd_lanes == 2'h1)
		else $error("odd byte not on lower lane");

	// ****************************************
	// count and event checks
	// ****************************************
	// a usb bus reset overrides every count, so a_bcnt_overwrite, a_lane_both, a_in_drain and a_out_fill skip the cycles it hits
	a_bcnt_overwrite: assert property (seq_wr_bcnt ##0 (!i_out_ack && !i_bus_reset)
			|=> s_q.bcnt[$past(sel)] == $past(wr16))
		else $error("byte count write lost");

	a_rd_bcnt: assert property (seq_rd_bcnt |=> o_avs.readdata == {16'h0000, $past(s_q.bcnt[sel])})
		else $error("byte count read mismatch");

	a_ctrl_mps: assert property (seq_wr_ctrl_mps |=> s_q.mps[$past(sel)] == $past(s_q.mps[sel]))
		else $error("control slot took sizing write");

	a_val_source: assert property (!i_pio_wr |=> !o_in_validate)
		else $error("validate without processor write");

	a_clr_source: assert property (!i_pio_rd |=> !o_out_clear)
		else $error("clear without processor read");

	a_fill_bus_rst: assert property (i_bus_reset |=> s_q.fill == '0)
		else $error("fill status not cleared");

	a_ppu_rsvd: assert property (o_pkts_per_microframe != 2'h3)
		else $error("reserved microframe code used");

	a_lane_both: assert property (i_pio_rd && !sel[0] && i_pio_wide && !i_bus_reset
			&& s_q.bcnt[sel] - s_q.rcnt != 16'h0001 |=> o_rd_lanes == 2'h3)
		else $error("wide read not on both lanes");

	a_in_drain: assert property (i_in_sent && !i_pio_wr && !i_bus_reset && s_q.fill[{i_in_sent_ep, 1'b1}] != 2'h0
			|=> s_q.fill[{$past(i_in_sent_ep), 1'b1}] == $past(s_q.fill[{i_in_sent_ep, 1'b1}]) - 2'h1)
		else $error("sent buffer not drained");

	a_out_fill: assert property (i_out_ack && !i_pio_rd && !i_bus_reset && s_q.fill[{i_out_ep, 1'b0}] != 2'h2
			|=> s_q.fill[{$past(i_out_ep), 1'b0}] == $past(s_q.fill[{i_out_ep, 1'b0}]) + 2'h1)
		else $error("received buffer not counted");
endmodule
`default_nettype wire

// >>> verification/usbs_fw_model.sv
`timescale 1ns/1ps
`default_nettype none
module usbs_fw_model (
	input wire logic i_core_clk,
	input wire usbs_pkg::usbs_avs_rsp_t i_rsp,
	output usbs_pkg::usbs_avs_req_t o_req
);
	import usbs_pkg::*;
	initial o_req = '0;
	// ****************************
	// avalon master cycle
	// ****************************
	// index first, small fifos: callers select endpoint and keep sizes tiny
	task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d, output logic [31:0] q);
		o_req <= '{address: a, read: !w, write: w, writedata: {16'h0000, d}, byteenable: 4'h3};
		// no cycle count assumed: only the bench watchdog ends a stuck wait
		do begin
			@(posedge i_core_clk);
		end while (i_rsp.waitrequest !== 1'b0);
		q = i_rsp.readdata;
		o_req <= '0;
		// one idle edge keeps every request a fresh assertion
		@(posedge i_core_clk);
	endtask
endmodule
`default_nettype wire

// >>> verification/usbs_ep_sizing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usbs_ep_sizing_tb;
	import usbs_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic bus_rst = 1'b0, hs = 1'b1, pwr = 1'b0, prd = 1'b0, pwide = 1'b0, sent = 1'b0, ack = 1'b0;
	logic [2:0] sent_ep = 3'h0, out_ep = 3'h0;
	logic [10:0] out_bytes = 11'h000;
	logic val, clr, lv, lc, early;
	logic [1:0] lanes, ppu, ll;
	logic [31:0] q;
	usbs_avs_req_t req;
	usbs_avs_rsp_t rsp;
	int num_errors = 0, num_checks = 0;
	always #4 i_core_clk = ~i_core_clk;
	usbs_ep_sizing u_usbs_ep_sizing (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_avs(req), .o_avs(rsp),
		.i_bus_reset(bus_rst), .i_high_speed(hs), .i_pio_wr(pwr), .i_pio_rd(prd), .i_pio_wide(pwide),
		.i_in_sent(sent), .i_in_sent_ep(sent_ep), .i_out_ack(ack), .i_out_ep(out_ep), .i_out_bytes(out_bytes),
		.o_in_validate(val), .o_out_clear(clr), .o_rd_lanes(lanes), .o_pkts_per_microframe(ppu));
	usbs_fw_model u_usbs_fw_model (.i_core_clk(i_core_clk), .i_rsp(rsp), .o_req(req));
	// ****************************
	// helpers
	// ****************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		u_usbs_fw_model.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		u_usbs_fw_model.xfer(1'b0, a, 16'h0000, q);
		chk(q, {16'h0000, e});
	endtask
	// answers land one edge after each pulse, so they are taken at the edge after the one that drops it
	task automatic pio(input logic w, input logic wide, input int n);
		early = 1'b0;
		for (int k = 0; k < n; k++) begin
			pwr <= w;
			prd <= !w;
			pwide <= wide;
			@(posedge i_core_clk);
			pwr <= 1'b0;
			prd <= 1'b0;
			@(posedge i_core_clk);
			if (k < n - 1)
				early = early | val | clr;
			lv = val;
			lc = clr;
			ll = lanes;
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		give_verdict;
	end
	// ****************************
	// scenarios
	// ****************************
	initial begin
		repeat (4) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		@(posedge i_core_clk);
		rd(10'h070, 16'h0000);
		rd(10'h078, 16'h0000);
		rd(10'h3FC, 16'h0000);
		wr(10'h0B0, 16'h0003);
		wr(10'h010, 16'hE008);
		rd(10'h010, 16'h0008);
		rd(10'h070, 16'h0008);
		wr(10'h070, 16'h0003);
		pio(1'b1, 1'b0, 3);
		chk({early, lv}, 32'h1);
		repeat (25) @(posedge i_core_clk);
		rd(10'h078, 16'h0001);
		sent <= 1'b1;
		sent_ep <= 3'h1;
		@(posedge i_core_clk);
		sent <= 1'b0;
		repeat (25) @(posedge i_core_clk);
		rd(10'h078, 16'h0000);
		wr(10'h010, 16'h0008);
		rd(10'h070, 16'h0008);
		pio(1'b1, 1'b1, 4);
		chk({early, lv}, 32'h1);
		pio(1'b1, 1'b1, 4);
		chk({early, lv}, 32'h1);
		repeat (25) @(posedge i_core_clk);
		rd(10'h078, 16'h0003);
		wr(10'h0B0, 16'h0004);
		ack <= 1'b1;
		out_ep <= 3'h2;
		out_bytes <= 11'h003;
		@(posedge i_core_clk);
		ack <= 1'b0;
		@(posedge i_core_clk);
		rd(10'h070, 16'h0003);
		pio(1'b0, 1'b1, 1);
		chk({ll, lc}, 32'h6);
		pio(1'b0, 1'b1, 1);
		chk({ll, lc}, 32'h3);
		bus_rst <= 1'b1;
		@(posedge i_core_clk);
		bus_rst <= 1'b0;
		@(posedge i_core_clk);
		rd(10'h070, 16'h0000);
		wr(10'h0B4, 16'h0001);
		for (int c = 0; c < 4; c++) begin
			wr(10'h010, {3'h0, 2'(c), 11'h008});
			chk(ppu, (c == 3) ? 32'h0 : 32'(c));
		end
		wr(10'h010, 16'h1008);
		hs <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		chk(ppu, 32'h0);
		hs <= 1'b1;
		wr(10'h0B4, 16'h0002);
		chk(ppu, 32'h0);
		wr(10'h0B0, 16'h0000);
		wr(10'h010, 16'h0040);
		rd(10'h010, 16'h0000);
		give_verdict;
	end
endmodule
`default_nettype wire
